// ===== common/scc_cfg.svh
// register offsets, field positions and reset values of the system control
`ifndef SCC_CFG_SVH
`define SCC_CFG_SVH
`define SCC_ADDR_W        8
`define SCC_OFF_CLKCFG    8'h00
`define SCC_OFF_MODE      8'h04
`define SCC_OFF_RUN_EN    8'h08
`define SCC_OFF_SLP_EN    8'h0c
`define SCC_OFF_DSL_EN    8'h10
`define SCC_OFF_PRST      8'h14
`define SCC_OFF_RAW       8'h18
`define SCC_OFF_IMASK     8'h1c
`define SCC_OFF_MIS       8'h20
`define SCC_OFF_ICLR      8'h24
`define SCC_OFF_RCAUSE    8'h28
`define SCC_OFF_LDO       8'h2c
`define SCC_OFF_SWRST     8'h30
`define SCC_OFF_PRESENT   8'h34
`define SCC_OFF_MEMSIZE   8'h38
`define SCC_OFF_PINS      8'h3c
`define SCC_OFF_STATUS    8'h40
`define SCC_CLK_SRC_LSB   0
`define SCC_PLL_REF_LSB   4
`define SCC_USE_PLL_BIT   6
`define SCC_DIV_LSB       8
`define SCC_MAIN_DIS_BIT  16
`define SCC_INT_DIS_BIT   17
`define SCC_GATE_BIT      18
`define SCC_XTAL_LSB      20
`define SCC_XTAL_MIN      5'h04
`define SCC_XTAL_MAX      5'h16
`define SCC_LDO_DEFAULT   4'h5
`define SCC_LDO_MAX       4'ha
`define SCC_NUM_INT       7
`define SCC_NUM_RC        5
`define SCC_MODE_SLEEP    2'h1
`define SCC_MODE_DEEP     2'h2
`define SCC_SWRST_KEY     32'h0000_0001
`define SCC_RST_PULSE     8'h10
`endif

// ===== common/scc_pkg.sv
// types shared by the system control block
package scc_pkg;
  typedef enum logic [2:0] {
    SRC_MAIN, SRC_INT, SRC_INT4, SRC_EXT, SRC_PLL
  } scc_src_e;
  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_DEEP} scc_pwr_e;
endpackage : scc_pkg

// ===== hdl/scc_top.sv
// system clock, reset and power control with register port
//
// Summary of operation
// - system clock from one of five sources
// - pll reference from any oscillator
// - sleep gates cpu, clocks unchanged
// - deep sleep: no pll, its reference oscillator direct
// - sleep on request, enabled interrupt wakes
// - five reset sources reset device
// - every reset cause recorded until cleared, readable
// - per-peripheral enable, disable and reset
// - separate sleep and deep-sleep enable sets
// - seven system interrupt events
// - per-source enable, latched until cleared
// - read-only sizes, presence and pins
// - ldo setting, default nominal
// - active oscillator cannot be disabled
// - system divider one to sixty-four
// - sleep enables only with clock gating
`timescale 1ns/1ns
`include "scc_cfg.svh"
module scc_top #(
  parameter int NPER    = 16,
  parameter logic [31:0] PRESENT_INFO = 32'h0000_ffff, // arbitrary
  parameter logic [31:0] MEMSIZE_INFO = 32'h0010_0040, // arbitrary
  parameter logic [31:0] PINS_INFO    = 32'h0000_00ff  // arbitrary
) (
  input  wire logic                   clk,       // 100 MHz clock
  input  wire logic                   arst_n,    // async reset, low
  input  wire logic [`SCC_ADDR_W-1:0] addr,      // register address
  input  wire logic [31:0]            wdata,     // write data
  input  wire logic                   wr,        // write strobe
  input  wire logic                   rd,        // read strobe
  output logic      [31:0]            rdata,     // read data, next cycle
  input  wire logic [6:0]             evt_in,    // raw interrupt events
  input  wire logic [4:0]             rst_evt,   // reset causes, pins
  input  wire logic                   wake_req,  // any enabled irq
  input  wire logic                   sleep_req, // cpu sleep instruction
  input  wire logic                   deep_req,  // sleep is deep
  output logic      [2:0]             clk_src,   // selected source
  output logic      [1:0]             pll_ref,   // pll reference
  output logic      [5:0]             sys_div,   // divider minus one
  output logic                        cpu_clk_en, // cpu clock gate
  output logic                        main_osc_en, // main oscillator on
  output logic                        int_osc_en,  // internal osc on
  output logic      [NPER-1:0]        per_clk_en,  // peripheral clocks
  output logic      [NPER-1:0]        per_rst,     // peripheral resets
  output logic                        sys_rst_req, // device reset
  output logic      [3:0]             ldo_set,     // ldo voltage code
  output logic                        irq          // system interrupt
);
  // the enable and reset words are 32 bits wide, so no more than that
  if (NPER < 1 || NPER > 32)
  begin : g_nper_chk
    $error("NPER out of range");
  end

  // ****************************************************************
  // state
  // ****************************************************************
  logic [31:0] clkcfg, run_en, slp_en, dsl_en, prst_reg;
  logic [6:0]  raw, imask;
  logic [4:0]  rcause;
  scc_pkg::scc_pwr_e pwr;
  logic [4:0]  rst_s1, rst_s2;
  logic [6:0]  evt_s1, evt_s2;
  logic        wake_s1, wake_s2;
  logic [7:0]  rst_cnt;
  logic [31:0] next_rdata;
  logic [2:0]  req_src;
  logic [2:0]  use_osc;   // oscillator that will feed the system

  wire wr_clk = wr && addr == `SCC_OFF_CLKCFG;
  wire gate   = clkcfg[`SCC_GATE_BIT];

  // two-flop synchronisers; first stage feeds only the second
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      rst_s1 <= 5'h00;
      rst_s2 <= 5'h00;
      evt_s1 <= 7'h00;
      evt_s2 <= 7'h00;
      wake_s1 <= 1'b0;
      wake_s2 <= 1'b0;
    end
    else
    begin
      rst_s1 <= rst_evt;
      rst_s2 <= rst_s1;
      evt_s1 <= evt_in;
      evt_s2 <= evt_s1;
      wake_s1 <= wake_req;
      wake_s2 <= wake_s1;
    end

  // ****************************************************************
  // clock configuration
  // ****************************************************************
  // oscillator in use may not be switched off; its disable bit is forced
  // a refused source keeps the old one, which must stay protected too
  always_comb
  begin
    req_src = wdata[`SCC_CLK_SRC_LSB +: 3];
    use_osc = 3'h0;
    if (req_src > 3'h4)
      req_src = clkcfg[`SCC_CLK_SRC_LSB +: 3];
    // pll reference codes share the codes of the four oscillators
    if (req_src == scc_pkg::SRC_PLL)
      use_osc = {1'b0, wdata[`SCC_PLL_REF_LSB +: 2]};
    else
      use_osc = req_src;
  end
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      clkcfg <= 32'h0000_0000;
    else if (wr_clk)
    begin
      clkcfg <= wdata;
      clkcfg[`SCC_CLK_SRC_LSB +: 3] <= req_src;
      // checked by software: an odd crystal code only skews rates
      if (use_osc == scc_pkg::SRC_MAIN)
        clkcfg[`SCC_MAIN_DIS_BIT] <= 1'b0;
      if (use_osc == scc_pkg::SRC_INT || use_osc == scc_pkg::SRC_INT4)
        clkcfg[`SCC_INT_DIS_BIT] <= 1'b0;
    end

  // deep sleep drops the pll and runs its reference oscillator directly,
  // so the system never lands on an oscillator that software switched off
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      clk_src <= 3'h0;
      pll_ref <= 2'h0;
      sys_div <= 6'h00;
      main_osc_en <= 1'b1;
      int_osc_en <= 1'b1;
    end
    else
    begin
      clk_src <= (pwr == scc_pkg::ST_DEEP &&
                  clkcfg[2:0] == scc_pkg::SRC_PLL) ?
                 {1'b0, clkcfg[`SCC_PLL_REF_LSB +: 2]} :
                 clkcfg[2:0];
      pll_ref <= clkcfg[`SCC_PLL_REF_LSB +: 2];
      sys_div <= clkcfg[`SCC_DIV_LSB +: 6];
      main_osc_en <= !clkcfg[`SCC_MAIN_DIS_BIT];
      // on by default; its disable bit switches it off
      int_osc_en  <= !clkcfg[`SCC_INT_DIS_BIT];
    end

  // ****************************************************************
  // power modes
  // ****************************************************************
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      pwr <= scc_pkg::ST_RUN;
    else
      case (pwr)
        scc_pkg::ST_RUN:
          if (sleep_req && deep_req) pwr <= scc_pkg::ST_DEEP;
          else if (sleep_req) pwr <= scc_pkg::ST_SLEEP;
        scc_pkg::ST_SLEEP, scc_pkg::ST_DEEP:
          if (wake_s2) pwr <= scc_pkg::ST_RUN;
        default: pwr <= scc_pkg::ST_RUN;
      endcase

  // cpu clock gated in both sleeps; peripheral sets per mode
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      cpu_clk_en <= 1'b1;
      per_clk_en <= '0;
    end
    else
    begin
      cpu_clk_en <= pwr == scc_pkg::ST_RUN;
      case (pwr)
        scc_pkg::ST_SLEEP:
          per_clk_en <= gate ? slp_en[NPER-1:0] : run_en[NPER-1:0];
        scc_pkg::ST_DEEP:
          per_clk_en <= gate ? dsl_en[NPER-1:0] : run_en[NPER-1:0];
        default: per_clk_en <= run_en[NPER-1:0];
      endcase
    end

  // ****************************************************************
  // peripheral enables and resets
  // ****************************************************************
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      run_en <= '0;
      slp_en <= '0;
      dsl_en <= '0;
      prst_reg <= '0;
    end
    else
    begin
      if (wr && addr == `SCC_OFF_RUN_EN) run_en <= wdata;
      if (wr && addr == `SCC_OFF_SLP_EN) slp_en <= wdata;
      if (wr && addr == `SCC_OFF_DSL_EN) dsl_en <= wdata;
      if (wr && addr == `SCC_OFF_PRST) prst_reg <= wdata;
    end
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n) per_rst <= '0;
    else per_rst <= prst_reg[NPER-1:0];

  // ****************************************************************
  // interrupts
  // ****************************************************************
  // set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      raw <= 7'h00;
      imask <= 7'h00;
    end
    else
    begin
      raw <= (raw & ~((wr && addr == `SCC_OFF_ICLR) ? wdata[6:0] : 7'h00))
             | evt_s2;
      if (wr && addr == `SCC_OFF_IMASK) imask <= wdata[6:0];
    end
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n) irq <= 1'b0;
    else irq <= |(raw & imask);

  // ****************************************************************
  // resets and cause record
  // ****************************************************************
  // cause flags have no async reset so they survive the device reset
  always_ff @(posedge clk)
    rcause <= (rcause & ~((wr && addr == `SCC_OFF_RCAUSE) ?
               wdata[4:0] : 5'h00)) | rst_s2 |
              {3'h0, wr && addr == `SCC_OFF_SWRST &&
               wdata == `SCC_SWRST_KEY, 1'b0};
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n) rst_cnt <= 8'h00;
    else if (|rst_s2 || (wr && addr == `SCC_OFF_SWRST &&
             wdata == `SCC_SWRST_KEY))
      rst_cnt <= `SCC_RST_PULSE;
    else if (rst_cnt != 8'h00)
      rst_cnt <= rst_cnt - 8'h01;
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n) sys_rst_req <= 1'b0;
    else sys_rst_req <= rst_cnt != 8'h00;

  // ldo code 0..10 covers the adjustable span, 5 is nominal
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n) ldo_set <= `SCC_LDO_DEFAULT;
    else if (wr && addr == `SCC_OFF_LDO && wdata[3:0] <= `SCC_LDO_MAX)
      ldo_set <= wdata[3:0];

  // ****************************************************************
  // read port
  // ****************************************************************
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (addr)
      `SCC_OFF_CLKCFG:  next_rdata = clkcfg;
      `SCC_OFF_MODE:    next_rdata = {30'h0, pwr};
      `SCC_OFF_RUN_EN:  next_rdata = run_en;
      `SCC_OFF_SLP_EN:  next_rdata = slp_en;
      `SCC_OFF_DSL_EN:  next_rdata = dsl_en;
      `SCC_OFF_PRST:    next_rdata = prst_reg;
      `SCC_OFF_RAW:     next_rdata = {25'h0, raw};
      `SCC_OFF_IMASK:   next_rdata = {25'h0, imask};
      `SCC_OFF_MIS:     next_rdata = {25'h0, raw & imask};
      `SCC_OFF_RCAUSE:  next_rdata = {27'h0, rcause};
      `SCC_OFF_LDO:     next_rdata = {28'h0, ldo_set};
      `SCC_OFF_PRESENT: next_rdata = PRESENT_INFO;
      `SCC_OFF_MEMSIZE: next_rdata = MEMSIZE_INFO;
      `SCC_OFF_PINS:    next_rdata = PINS_INFO;
      `SCC_OFF_STATUS:  next_rdata = {24'h0, per_clk_en[0], cpu_clk_en,
                                     sys_div};
      default:          next_rdata = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n) rdata <= 32'h0000_0000;
    else if (rd) rdata <= next_rdata;
    else rdata <= 32'h0000_0000;

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_pend;
    (raw & imask) != 7'h00;
  endsequence
  sequence s_wake;
    pwr != scc_pkg::ST_RUN && wake_s2;
  endsequence
  sequence s_sleep;
    pwr == scc_pkg::ST_RUN && sleep_req;
  endsequence
  AST_IRQ: assert property (@(posedge clk) disable iff (!arst_n)
    s_pend |=> irq) else $error("irq missing");
  AST_LATCH: assert property (@(posedge clk) disable iff (!arst_n)
    (raw[0] && !(wr && addr == `SCC_OFF_ICLR)) |=> raw[0])
    else $error("raw flag lost");
  AST_WAKE: assert property (@(posedge clk) disable iff (!arst_n)
    s_wake |=> ##1 cpu_clk_en)
    else $error("no wake");
  AST_SLEEP: assert property (@(posedge clk) disable iff (!arst_n)
    s_sleep |=> ##1 !cpu_clk_en)
    else $error("cpu not gated");
  AST_DEEP: assert property (@(posedge clk) disable iff (!arst_n)
    (pwr == scc_pkg::ST_DEEP) |=> clk_src != 3'(scc_pkg::SRC_PLL))
    else $error("pll in deep");
  AST_NOOFF: assert property (@(posedge clk) disable iff (!arst_n)
    (clkcfg[2:0] == scc_pkg::SRC_MAIN) |-> !clkcfg[`SCC_MAIN_DIS_BIT])
    else $error("active osc off");
  AST_INTON: assert property (@(posedge clk) disable iff (!arst_n)
    (clkcfg[2:0] == scc_pkg::SRC_INT || clkcfg[2:0] == scc_pkg::SRC_INT4)
    |-> !clkcfg[`SCC_INT_DIS_BIT]) else $error("active osc off");
  AST_SRC: assert property (@(posedge clk) disable iff (!arst_n)
    clkcfg[2:0] <= 3'h4) else $error("bad source");
  AST_LDO: assert property (@(posedge clk) disable iff (!arst_n)
    ldo_set <= `SCC_LDO_MAX) else $error("ldo out of span");
  AST_RST: assert property (@(posedge clk) disable iff (!arst_n)
    (|rst_s2) |=> ##1 sys_rst_req) else $error("no reset");
  // run_en may be written in the same cycle, so compare with its old value
  AST_GATE: assert property (@(posedge clk) disable iff (!arst_n)
    (!gate && pwr == scc_pkg::ST_DEEP) |=>
    per_clk_en == $past(run_en[NPER-1:0])) else $error("gating off");
endmodule : scc_top

// ===== testbench/system_clock_reset_power_control_bench.sv
// self-checking bench of the system clock, reset and power control
`timescale 1ns/1ns
`include "scc_cfg.svh"
module system_clock_reset_power_control_bench;
  // ************************************************************
  // info words handed to the block, values arbitrary
  // ************************************************************
  localparam logic [31:0] PRES = 32'h0000_a5c3;
  localparam logic [31:0] MEMS = 32'h0020_0080;
  localparam logic [31:0] PINS = 32'h0000_3c0f;
  logic        clk       = 1'b0;
  logic        arst_n    = 1'b0;
  logic [7:0]  addr      = 8'h00;
  logic [31:0] wdata     = 32'h0000_0000;
  logic        wr        = 1'b0;
  logic        rd        = 1'b0;
  logic [6:0]  evt_in    = 7'h00;
  logic [4:0]  rst_evt   = 5'h00;
  logic        wake_req  = 1'b0;
  logic        sleep_req = 1'b0;
  logic        deep_req  = 1'b0;
  logic [31:0] rdata;
  logic [2:0]  clk_src;
  logic [1:0]  pll_ref;
  logic [5:0]  sys_div;
  logic        cpu_clk_en;
  logic        main_osc_en;
  logic        int_osc_en;
  logic [15:0] per_clk_en;
  logic [15:0] per_rst;
  logic        sys_rst_req;
  logic [3:0]  ldo_set;
  logic        irq;
  logic [31:0] v;
  int          failures        = 0;
  int          samples_checked = 0;
  scc_top #(.NPER(16), .PRESENT_INFO(PRES), .MEMSIZE_INFO(MEMS),
    .PINS_INFO(PINS)) scc_top_inst (.clk(clk), .arst_n(arst_n),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .evt_in(evt_in), .rst_evt(rst_evt), .wake_req(wake_req),
    .sleep_req(sleep_req), .deep_req(deep_req), .clk_src(clk_src),
    .pll_ref(pll_ref), .sys_div(sys_div), .cpu_clk_en(cpu_clk_en),
    .main_osc_en(main_osc_en), .int_osc_en(int_osc_en),
    .per_clk_en(per_clk_en), .per_rst(per_rst),
    .sys_rst_req(sys_rst_req), .ldo_set(ldo_set), .irq(irq));
  // 10 ns clock
  always #5 clk = ~clk;
  // ************************************************************
  // shared bus, wait and compare tasks
  // ************************************************************
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // n edges, each followed by a wait so its updates land before sampling
  task automatic cyc(input int n);
    repeat (n) @(posedge clk) #1;
  endtask : cyc
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wreg
  // read data stand only in the cycle after the strobe
  task automatic rreg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 v = rdata;
  endtask : rreg
  // sleep request pulse; wake is a level held until the cpu runs
  task automatic go_sleep(input logic deep);
    @(posedge clk);
    sleep_req <= 1'b1;
    deep_req  <= deep;
    @(posedge clk);
    sleep_req <= 1'b0;
    for (int i = 0; i < 8 && cpu_clk_en !== 1'b0; i++) cyc(1);
  endtask : go_sleep
  task automatic wake;
    @(posedge clk);
    wake_req <= 1'b1;
    for (int i = 0; i < 10 && cpu_clk_en !== 1'b1; i++) cyc(1);
    wake_req <= 1'b0;
  endtask : wake
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    cyc(1);
    chk("clk_src", 0, clk_src);
    chk("cpu_clk_en", 1, cpu_clk_en);
    chk("osc_en", 3, {main_osc_en, int_osc_en});
    chk("ldo_set", `SCC_LDO_DEFAULT, ldo_set);
    chk("irq", 0, irq);
  endtask : t_reset
  // every source, every pll reference, divider 1 and 64 at the ends
  task automatic t_clock;
    logic [5:0]  d;
    logic [31:0] w;
    for (int s = 0; s < 5; s++)
    begin
      d = 6'(s * 16 - (s > 0 ? 1 : 0));
      w = s | ((s % 4) << 4) | ((s == 4) << 6) | (d << 8);
      // the pll gets a declared crystal code inside the legal span
      if (s == 4) w[`SCC_XTAL_LSB +: 5] = `SCC_XTAL_MAX;
      wreg(`SCC_OFF_CLKCFG, w);
      cyc(2);
      chk("clk_src", s, clk_src);
      chk("pll_ref", s % 4, pll_ref);
      chk("sys_div", d, sys_div);
      rreg(`SCC_OFF_CLKCFG);
      chk("clkcfg", w, v);
    end
    rreg(`SCC_OFF_STATUS);
    chk("status", 32'h0000_007f, v);
    wreg(`SCC_OFF_CLKCFG, 32'h0000_0005);
    cyc(2);
    chk("clk_src kept", 4, clk_src);
    wreg(`SCC_OFF_CLKCFG, 32'h0003_0000);
    cyc(2);
    chk("osc_en", 2, {main_osc_en, int_osc_en});
    // refused source: the main oscillator still runs the system
    wreg(`SCC_OFF_CLKCFG, 32'h0003_0007);
    cyc(2);
    chk("clk_src kept", 0, clk_src);
    chk("osc_en kept", 2, {main_osc_en, int_osc_en});
  endtask : t_clock
  // each source alone enabled, its neighbour raised but masked
  task automatic t_irq;
    logic [6:0] m;
    for (int i = 0; i < `SCC_NUM_INT; i++)
    begin
      m = 7'h01 << i;
      wreg(`SCC_OFF_IMASK, {25'h0, m});
      @(posedge clk);
      evt_in <= m | (7'h01 << ((i + 1) % 7));
      for (int k = 0; k < 10 && irq !== 1'b1; k++) cyc(1);
      evt_in <= 7'h00;
      cyc(6);
      chk("irq", 1, irq);
      rreg(`SCC_OFF_RAW);
      chk("raw", m | (7'h01 << ((i + 1) % 7)), v);
      rreg(`SCC_OFF_MIS);
      chk("mis", m, v);
      wreg(`SCC_OFF_ICLR, 32'h0000_007f);
      cyc(3);
      chk("irq", 0, irq);
    end
  endtask : t_irq
  // pll selected with gating on, then sleep and deep sleep
  task automatic t_modes;
    wreg(`SCC_OFF_RUN_EN, 32'h0000_00ff);
    wreg(`SCC_OFF_SLP_EN, 32'h0000_0f0f);
    wreg(`SCC_OFF_DSL_EN, 32'h0000_0033);
    wreg(`SCC_OFF_CLKCFG, 32'h0004_0044);
    cyc(2);
    chk("per_clk_en", 16'h00ff, per_clk_en);
    go_sleep(1'b0);
    cyc(5);
    chk("cpu_clk_en", 0, cpu_clk_en);
    chk("clk_src", 4, clk_src);
    chk("per_clk_en", 16'h0f0f, per_clk_en);
    rreg(`SCC_OFF_MODE);
    chk("mode", `SCC_MODE_SLEEP, v);
    wake;
    chk("cpu_clk_en", 1, cpu_clk_en);
    go_sleep(1'b1);
    cyc(2);
    chk("cpu_clk_en", 0, cpu_clk_en);
    chk("clk_src", 0, clk_src);
    chk("per_clk_en", 16'h0033, per_clk_en);
    wake;
    cyc(2);
    chk("clk_src", 4, clk_src);
    chk("per_clk_en", 16'h00ff, per_clk_en);
    // gating off: deep sleep keeps every run-mode enable
    wreg(`SCC_OFF_CLKCFG, 32'h0000_0044);
    go_sleep(1'b1);
    cyc(2);
    chk("per_clk_en", 16'h00ff, per_clk_en);
    chk("clk_src", 0, clk_src);
    rreg(`SCC_OFF_MODE);
    chk("mode", `SCC_MODE_DEEP, v);
    wake;
    chk("cpu_clk_en", 1, cpu_clk_en);
  endtask : t_modes
  task automatic t_per_ldo;
    wreg(`SCC_OFF_PRST, 32'h0000_8001);
    cyc(2);
    chk("per_rst", 16'h8001, per_rst);
    wreg(`SCC_OFF_LDO, 32'h0000_000a);
    wreg(`SCC_OFF_LDO, 32'h0000_000b);
    cyc(2);
    chk("ldo_set", `SCC_LDO_MAX, ldo_set);
    wreg(`SCC_OFF_LDO, 32'h0000_0000);
    cyc(2);
    chk("ldo_set", 0, ldo_set);
  endtask : t_per_ldo
  // software reset pulse length, then an external cause added
  task automatic t_rcause;
    int n;
    wreg(`SCC_OFF_RCAUSE, 32'h0000_001f);
    rreg(`SCC_OFF_RCAUSE);
    chk("rcause", 0, v);
    wreg(`SCC_OFF_SWRST, `SCC_SWRST_KEY);
    for (int i = 0; i < 10 && sys_rst_req !== 1'b1; i++) cyc(1);
    n = 0;
    while (sys_rst_req === 1'b1 && n < 40) begin cyc(1); n++; end
    chk("rst pulse", `SCC_RST_PULSE, n);
    rreg(`SCC_OFF_RCAUSE);
    chk("rcause", 32'h0000_0002, v);
    @(posedge clk);
    rst_evt <= 5'h04;
    cyc(4);
    rst_evt <= 5'h00;
    cyc(30);
    rreg(`SCC_OFF_RCAUSE);
    chk("rcause", 32'h0000_0006, v);
    // a device reset in mid-run leaves the cause record alone
    @(posedge clk);
    arst_n <= 1'b0;
    cyc(2);
    arst_n <= 1'b1;
    rreg(`SCC_OFF_RCAUSE);
    chk("rcause", 32'h0000_0006, v);
    chk("ldo_set", `SCC_LDO_DEFAULT, ldo_set);
    wreg(`SCC_OFF_RCAUSE, 32'h0000_0002);
    rreg(`SCC_OFF_RCAUSE);
    chk("rcause", 32'h0000_0004, v);
  endtask : t_rcause
  task automatic t_info;
    rreg(`SCC_OFF_PRESENT);
    chk("present", PRES, v);
    rreg(`SCC_OFF_MEMSIZE);
    chk("memsize", MEMS, v);
    rreg(`SCC_OFF_PINS);
    chk("pins", PINS, v);
    rreg(8'h50);
    chk("unmapped", 0, v);
  endtask : t_info
  task automatic finish_test;
    if (failures == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test
  // main sequence after a five cycle reset
  initial
  begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    t_reset;
    t_clock;
    t_irq;
    t_modes;
    t_per_ldo;
    t_rcause;
    t_info;
    finish_test;
  end
  // the whole run needs a few thousand cycles at most
  initial
  begin
    #200000;
    failures++;
    finish_test;
  end
endmodule : system_clock_reset_power_control_bench
